// >>> inc/pwm_pkg.sv
package pwm_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [2:0] OFS_MODE    = 3'h0;
  localparam logic [2:0] OFS_COMPARE = 3'h1;
  localparam logic [2:0] OFS_FFCTL   = 3'h2;
  localparam logic [2:0] OFS_RUN     = 3'h3;
  localparam logic [2:0] OFS_STATUS  = 3'h4;
  localparam logic [2:0] OFS_COUNT   = 3'h5;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int MODE_SEL_BIT   = 6;
  localparam int INT_SEL_BIT    = 5;
  localparam int DB_EN_BIT      = 4;
  localparam int FF_PRESET1_BIT = 2;
  localparam int FF_PRESET0_BIT = 3;
  localparam int RUN_BIT        = 0;

  // ---------------------------------------------------------------
  // Reset values and counts
  // ---------------------------------------------------------------
  localparam logic [6:0] MODE_RESET    = 7'h00;
  localparam logic [1:0] TRIG_RESET    = 2'h0;
  localparam logic [7:0] CMP_RESET     = 8'h00;
  localparam logic [3:0] PRESC_RESET   = 4'h0;
  localparam logic [7:0] TOP_LEN6      = 8'h3F;
  localparam logic [7:0] TOP_LEN7      = 8'h7F;
  localparam logic [7:0] TOP_LEN8      = 8'hFF;
  localparam logic [3:0] PRESC_MASK_4  = 4'h3;
  localparam logic [3:0] PRESC_MASK_16 = 4'hF;

  // Output flip-flop trigger selections.
  localparam logic [1:0] TRIG_NONE      = 2'h0;
  localparam logic [1:0] TRIG_INVERT    = 2'h1;
  localparam logic [1:0] TRIG_MATCH_SET = 2'h2;
  localparam logic [1:0] TRIG_MATCH_CLR = 2'h3;

  typedef struct packed {
    logic       mode_select_bit;
    logic       interrupt_select_bit;
    logic       double_buffer_enable;
    logic [1:0] len_sel;
    logic [1:0] clk_sel;
  } mode_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } bus_req_t;

  typedef enum logic [1:0] {
    ST_STOP = 2'b01,
    ST_RUN  = 2'b10
  } run_state_t;

endpackage

// >>> rtl/pwm_tick_prescaler.sv
`timescale 1ns/1ns
module pwm_tick_prescaler
  import pwm_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       run,
  input  wire logic [1:0] clk_sel,
  output logic            tick
);

  logic [3:0] presc_r;

  // The divider is held at zero while stopped, so the first tick after
  // a start always comes a full input period later.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      presc_r <= PRESC_RESET;
    end else if (!run) begin
      presc_r <= PRESC_RESET;
    end else begin
      presc_r <= presc_r + 4'h1;
    end
  end

  always_comb begin
    case (clk_sel)
      2'h0:    tick = run;
      2'h1:    tick = run && ((presc_r & PRESC_MASK_4) == PRESC_MASK_4);
      default: tick = run && (presc_r == PRESC_MASK_16);
    endcase
  end

endmodule

// >>> rtl/pwm_compare_buffer.sv
`timescale 1ns/1ns
module pwm_compare_buffer
  import pwm_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       wr_en,
  input  wire logic [7:0] wdata,
  input  wire logic       db_en,
  input  wire logic       load,
  output logic [7:0]      buffer_q,
  output logic [7:0]      active_q
);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      buffer_q <= CMP_RESET;
    end else if (wr_en) begin
      buffer_q <= wdata;
    end
  end

  // A load in the same cycle as a buffered write takes the old buffer.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      active_q <= CMP_RESET;
    end else if (wr_en && !db_en) begin
      active_q <= wdata;
    end else if (load && db_en) begin
      active_q <= buffer_q;
    end
  end

endmodule

// >>> rtl/pwm_interval_timer_8bit.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Trigger 11: match clears, overflow sets output.
// - Trigger 10: match sets, overflow clears output.
// - PWM mode clears counter at 2^n-1.
// - Overflow action beats match in same count.
// - Trigger 10 with compare 2^n-1: always low.
// - Trigger 11 with compare 2^n-1: always high.
// - PWM double buffer loads on each overflow.
// - PWM period is 2^n-1 input ticks.
// - PWM overflow raises interrupt when selected.
// - Channel is self-contained, independent of others.
// - Interval match interrupts only with bit 5 set.
// - Run zero stops and clears; one restarts.
// - Interval mode with trigger 01 toggles output on each match.
// - Control write can preset output to one.
// - Interval mode clears counter on match.
// - Buffered writes hit buffer only; else both.
// - Compare reads return the buffer contents.
// - Mode select resets to zero, PWM mode.
module pwm_interval_timer_8bit
  import pwm_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               rstn,
  input  wire pwm_pkg::bus_req_t  bus_req,
  output logic [7:0]              rdata,
  output logic                    timer_output_pin,
  output logic                    channel_timer_interrupt
);

  import pwm_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  mode_t      channel_mode_register;
  logic [1:0] flipflop_trigger_select;
  run_state_t state_r;
  run_state_t state_nxt;
  logic [7:0] pwm_up_counter;
  logic [7:0] cnt_nxt;
  logic [7:0] top;
  logic [7:0] cmp_buffer;
  logic [7:0] pwm_compare_register;
  logic       pwm_output_flipflop;
  logic       irq_r;
  logic [7:0] rdata_r;
  logic       tick;
  logic       run_eff;
  logic       pwm_mode;
  logic       wr_mode;
  logic       wr_cmp;
  logic       wr_ffctl;
  logic       wr_run;
  logic       stop_wr;
  logic       at_top;
  logic       hit;
  logic       ovf_ev;
  logic       match_ev;
  logic       cmp_load;
  logic       preset1;
  logic       preset0;

  assign wr_mode  = bus_req.wr && (bus_req.addr == OFS_MODE);
  assign wr_cmp   = bus_req.wr && (bus_req.addr == OFS_COMPARE);
  assign wr_ffctl = bus_req.wr && (bus_req.addr == OFS_FFCTL);
  assign wr_run   = bus_req.wr && (bus_req.addr == OFS_RUN);
  assign stop_wr  = wr_run && !bus_req.wdata[RUN_BIT];
  assign preset1  = wr_ffctl && bus_req.wdata[FF_PRESET1_BIT];
  assign preset0  = wr_ffctl && bus_req.wdata[FF_PRESET0_BIT];
  assign pwm_mode = !channel_mode_register.mode_select_bit;

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  // PWM after reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      channel_mode_register <= MODE_RESET;
    end else if (wr_mode) begin
      channel_mode_register <= bus_req.wdata[6:0];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      flipflop_trigger_select <= TRIG_RESET;
    end else if (wr_ffctl) begin
      flipflop_trigger_select <= bus_req.wdata[1:0];
    end
  end

  // ---------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_STOP: begin
        if (wr_run && bus_req.wdata[RUN_BIT]) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (stop_wr) begin
          state_nxt = ST_STOP;
        end
      end
      default: state_nxt = ST_STOP;
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_STOP;
    end else begin
      state_r <= state_nxt;
    end
  end

  // A stop write takes effect in its own cycle so no stray count slips in.
  assign run_eff = (state_r == ST_RUN) && !stop_wr;

  pwm_tick_prescaler u_presc (
    .clock   (clock),
    .rstn    (rstn),
    .run     (run_eff),
    .clk_sel (channel_mode_register.clk_sel),
    .tick    (tick)
  );

  // ---------------------------------------------------------------
  // Counter and events
  // ---------------------------------------------------------------
  // period length
  always_comb begin
    case (channel_mode_register.len_sel)
      2'h0:    top = TOP_LEN6;
      2'h1:    top = TOP_LEN7;
      default: top = TOP_LEN8;
    endcase
  end

  // The match compares the value being entered, so the output moves on
  // the same edge that the counter reaches the compare value.
  assign cnt_nxt  = pwm_up_counter + 8'h01;
  assign at_top   = (cnt_nxt == top);
  assign hit      = (cnt_nxt == pwm_compare_register);
  assign ovf_ev   = tick && pwm_mode && at_top;
  assign match_ev = tick && hit;
  assign cmp_load = pwm_mode ? ovf_ev : match_ev;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pwm_up_counter <= CMP_RESET;
    end else if (!run_eff) begin
      pwm_up_counter <= CMP_RESET;
    end else if (tick) begin
      if ((pwm_mode && at_top) || (!pwm_mode && hit)) begin
        pwm_up_counter <= CMP_RESET;
      end else begin
        pwm_up_counter <= cnt_nxt;
      end
    end
  end

  pwm_compare_buffer u_cmp (
    .clock    (clock),
    .rstn     (rstn),
    .wr_en    (wr_cmp),
    .wdata    (bus_req.wdata),
    .db_en    (channel_mode_register.double_buffer_enable),
    .load     (cmp_load),
    .buffer_q (cmp_buffer),
    .active_q (pwm_compare_register)
  );

  // ---------------------------------------------------------------
  // Output flip-flop
  // ---------------------------------------------------------------
  // A software preset wins over a coincident timer event.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pwm_output_flipflop <= 1'b0;
    end else if (preset1) begin
      pwm_output_flipflop <= 1'b1;
    end else if (preset0) begin
      pwm_output_flipflop <= 1'b0;
    end else if (ovf_ev) begin
      if (flipflop_trigger_select == TRIG_MATCH_CLR) begin
        pwm_output_flipflop <= 1'b1;
      end else if (flipflop_trigger_select == TRIG_MATCH_SET) begin
        pwm_output_flipflop <= 1'b0;
      end
    end else if (match_ev && pwm_mode) begin
      if (flipflop_trigger_select == TRIG_MATCH_CLR) begin
        pwm_output_flipflop <= 1'b0;
      end else if (flipflop_trigger_select == TRIG_MATCH_SET) begin
        pwm_output_flipflop <= 1'b1;
      end
    end else if (match_ev && flipflop_trigger_select == TRIG_INVERT) begin
      pwm_output_flipflop <= !pwm_output_flipflop;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt and read data
  // ---------------------------------------------------------------
  // overflow interrupt, match interrupt in interval mode
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= channel_mode_register.interrupt_select_bit && cmp_load;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 8'h00;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        OFS_MODE:    rdata_r <= {1'b0, channel_mode_register};
        OFS_COMPARE: rdata_r <= cmp_buffer;
        OFS_FFCTL:   rdata_r <= {6'h00, flipflop_trigger_select};
        OFS_RUN:     rdata_r <= {7'h00, state_r == ST_RUN};
        OFS_STATUS:  rdata_r <= {7'h00, pwm_output_flipflop};
        OFS_COUNT:   rdata_r <= pwm_up_counter;
        default:     rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign timer_output_pin        = pwm_output_flipflop;
  assign channel_timer_interrupt = irq_r;
  assign rdata                   = rdata_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  chk_overflow_clear: assert property (
    ovf_ev && run_eff |=> pwm_up_counter == 8'h00)
    else $error("counter not cleared at overflow");
  chk_period_top: assert property (
    ovf_ev |-> pwm_up_counter == top - 8'h01)
    else $error("overflow at wrong count");
  chk_ovf_sets_out: assert property (
    ovf_ev && flipflop_trigger_select == TRIG_MATCH_CLR && !wr_ffctl
    |=> pwm_output_flipflop)
    else $error("overflow did not set output");
  chk_ovf_clears_out: assert property (
    ovf_ev && flipflop_trigger_select == TRIG_MATCH_SET && !wr_ffctl
    |=> !pwm_output_flipflop)
    else $error("overflow did not clear output");
  chk_match_sets_out: assert property (
    match_ev && pwm_mode && !at_top && !wr_ffctl &&
    flipflop_trigger_select == TRIG_MATCH_SET |=> pwm_output_flipflop)
    else $error("match did not set output");
  chk_zero_duty: assert property (
    pwm_mode && pwm_compare_register == top && !pwm_output_flipflop &&
    flipflop_trigger_select == TRIG_MATCH_SET && !wr_ffctl
    && !wr_mode && !wr_cmp |=> !pwm_output_flipflop)
    else $error("zero duty output went high");
  chk_full_duty: assert property (
    pwm_mode && pwm_compare_register == top && pwm_output_flipflop &&
    flipflop_trigger_select == TRIG_MATCH_CLR && !wr_ffctl
    && !wr_mode && !wr_cmp |=> pwm_output_flipflop)
    else $error("full duty output went low");
  chk_db_load: assert property (
    ovf_ev && channel_mode_register.double_buffer_enable && !wr_cmp
    |=> pwm_compare_register == $past(cmp_buffer))
    else $error("buffer not loaded at overflow");
  chk_irq_overflow: assert property (
    ovf_ev && channel_mode_register.interrupt_select_bit
    |=> channel_timer_interrupt)
    else $error("missing overflow interrupt");
  chk_irq_gated: assert property (
    channel_timer_interrupt |-> $past(
    channel_mode_register.interrupt_select_bit))
    else $error("interrupt without select bit");
  chk_stop_clears: assert property (
    stop_wr |=> pwm_up_counter == 8'h00 ##1 pwm_up_counter == 8'h00)
    else $error("stop did not clear counter");
  chk_match_toggle: assert property (
    match_ev && !pwm_mode && !wr_ffctl &&
    flipflop_trigger_select == TRIG_INVERT
    |=> pwm_output_flipflop != $past(pwm_output_flipflop))
    else $error("output not toggled on match");
  chk_preset_one: assert property (
    preset1 |=> pwm_output_flipflop)
    else $error("preset did not set output");
  chk_match_clear: assert property (
    match_ev && !pwm_mode && run_eff |=> pwm_up_counter == 8'h00)
    else $error("interval match did not clear");
  chk_direct_write: assert property (
    wr_cmp && !channel_mode_register.double_buffer_enable
    |=> pwm_compare_register == $past(bus_req.wdata))
    else $error("direct compare write lost");
  chk_read_buffer: assert property (
    bus_req.rd && bus_req.addr == OFS_COMPARE |=> rdata == $past(cmp_buffer))
    else $error("compare read not buffer");

  cov_pwm_overflow: cover property (ovf_ev ##[1:300] ovf_ev);
  cov_interval_match: cover property (match_ev && !pwm_mode);
  cov_irq: cover property (channel_timer_interrupt);
  cov_db_load: cover property (
    ovf_ev && channel_mode_register.double_buffer_enable);

endmodule

// >>> testbench/pwm_interval_timer_8bit_bench.sv
`timescale 1ns/1ns
module pwm_interval_timer_8bit_bench;
  import pwm_pkg::*;

  // ---------------------------------------------------------------
  // Stimulus and observation
  // ---------------------------------------------------------------
  logic       clock;
  logic       rstn;
  bus_req_t   bus_req;
  logic [7:0] rdata;
  logic       pin;
  logic       irq;
  int         mismatches;
  int         checked;

  // Rows: mode, flip-flop control, compare, period and high clocks.
  localparam logic [7:0] PM [10] = '{8'h20, 8'h20, 8'h24, 8'h28, 8'h2C,
                                     8'h20, 8'h20, 8'h21, 8'h22, 8'h23};
  localparam logic [7:0] PF [10] = '{8'h02, 8'h03, 8'h02, 8'h03, 8'h02,
                                     8'h02, 8'h03, 8'h03, 8'h02, 8'h03};
  localparam logic [7:0] PC [10] = '{8'h10, 8'h10, 8'h3C, 8'h80, 8'hF0,
                                     8'h3F, 8'h3F, 8'h10, 8'h38, 8'h08};
  localparam int PP [10] = '{63, 63, 127, 255, 255, 63, 63, 252, 1008, 1008};
  localparam int PH [10] = '{47, 16, 67, 128, 15, 0, 63, 64, 112, 128};

  pwm_interval_timer_8bit uut (
    .clock                   (clock),
    .rstn                    (rstn),
    .bus_req                 (bus_req),
    .rdata                   (rdata),
    .timer_output_pin        (pin),
    .channel_timer_interrupt (irq)
  );

  initial clock = 1'b0;
  always #5 clock = ~clock;

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    bus_req <= '0;
  endtask

  // Read data stand only in the cycle after the strobe is taken.
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clock);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    bus_req <= '0;
    #1 check({8'h00, rdata}, {8'h00, exp});
  endtask

  task automatic cfg(input logic [7:0] md, input logic [7:0] cmp,
                     input logic [7:0] ff);
    wr(OFS_RUN, 8'h00);
    wr(OFS_MODE, md);
    wr(OFS_COMPARE, cmp);
    wr(OFS_FFCTL, ff);
    wr(OFS_RUN, 8'h01);
  endtask

  // Measures one full interrupt period; the first period after a start
  // may be partial, so it is skipped.
  task automatic measure(output int per, output int hi);
    int n;
    n = 0;
    per = 0;
    hi = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge clock);
      #1 n++;
    end
    do begin
      @(posedge clock);
      #1 per++;
      if (pin === 1'b1) hi++;
    end while (irq !== 1'b1 && per < 3000);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rd_chk(OFS_MODE, 8'h00);
    rd_chk(OFS_COMPARE, 8'h00);
    rd_chk(OFS_STATUS, 8'h00);
    rd_chk(OFS_COUNT, 8'h00);
    rd_chk(OFS_FFCTL, 8'h00);
    wr(3'h7, 8'hFF);
    rd_chk(3'h7, 8'h00);
    rd_chk(3'h6, 8'h00);
  endtask

  task automatic t_pwm();
    int per;
    int hi;
    for (int i = 0; i < 10; i++) begin
      cfg(PM[i], PC[i], PF[i]);
      measure(per, hi);
      check(per[15:0], PP[i][15:0]);
      check(hi[15:0], PH[i][15:0]);
    end
  endtask

  task automatic t_dbuf();
    int n;
    int per;
    int hi;
    wr(OFS_RUN, 8'h00);
    wr(OFS_MODE, 8'h20);
    wr(OFS_COMPARE, 8'h10);
    wr(OFS_MODE, 8'h30);
    wr(OFS_COMPARE, 8'h20);
    rd_chk(OFS_COMPARE, 8'h20);
    wr(OFS_FFCTL, 8'h07);
    rd_chk(OFS_STATUS, 8'h01);
    wr(OFS_RUN, 8'h01);
    n = 0;
    while (pin === 1'b1 && n < 200) begin
      @(posedge clock);
      #1 n++;
    end
    check(n[15:0], 16'h0010);
    measure(per, hi);
    check(hi[15:0], 16'h0020);
    wr(OFS_RUN, 8'h00);
    rd_chk(OFS_COUNT, 8'h00);
    wr(OFS_FFCTL, 8'h0B);
    rd_chk(OFS_STATUS, 8'h00);
  endtask

  task automatic t_interval();
    int per;
    int h1;
    int h2;
    int n;
    cfg(8'h60, 8'h05, 8'h01);
    measure(per, h1);
    check(per[15:0], 16'h0005);
    measure(per, h2);
    check(h1[15:0] + h2[15:0], 16'h0005);
    cfg(8'h60, 8'h00, 8'h01);
    measure(per, h1);
    check(per[15:0], 16'h0100);
    cfg(8'h40, 8'h05, 8'h01);
    n = 0;
    h1 = 0;
    repeat (40) begin
      @(posedge clock);
      #1 if (irq !== 1'b0) n++;
      if (pin === 1'b1) h1++;
    end
    check(n[15:0], 16'h0000);
    check(h1[15:0], 16'h0014);
    // Buffered interval load at match; trigger none keeps the preset low.
    wr(OFS_RUN, 8'h00);
    wr(OFS_MODE, 8'h60);
    wr(OFS_COMPARE, 8'h05);
    cfg(8'h70, 8'h08, 8'h08);
    measure(per, h1);
    check(per[15:0], 16'h0008);
    check(h1[15:0], 16'h0000);
  endtask

  // ---------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    rstn = 1'b0;
    bus_req = '0;
    mismatches = 0;
    checked = 0;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    t_reset();
    t_pwm();
    t_dbuf();
    t_interval();
    give_verdict();
  end

  // The whole sequence needs under 10000 clocks; the limit allows twice that.
  initial begin
    #200_000;
    mismatches++;
    give_verdict();
  end
endmodule
